/* core/daao_ctrl.sv */
// memory controller end: register port, request fifo, command sequencer
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "daao_regs.svh"
module daao_ctrl import daao_pkg::*; #(
  parameter int FIFO_DEPTH = 8, // queued requests
  parameter int FAW_CK = `DAAO_FAW_CK, // rolling activate window, clocks
  parameter int TRP_CK = `DAAO_TRP_CK // single bank precharge, clocks
) (
  input wire logic mclk, // clock
  input wire logic reset, // sync reset, high
  input wire logic [7:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after strobe
  daao_link_if.ctl link // pins toward the device
);
  if (FAW_CK < 1 || FAW_CK > 200 || TRP_CK < 1 || TRP_CK > 200) begin : g_bad_timing
    $error("bad timing");
  end
  typedef enum logic [2:0] {
    C_IDLE = 3'b000, C_MODE = 3'b001, C_ACT = 3'b011, C_COL = 3'b010,
    C_HOLD = 3'b110, C_PRE = 3'b111, C_WAITP = 3'b101, C_SREF = 3'b100
  } daao_cst_t;
  typedef struct packed {
    daao_cst_t st;
    logic [11:0] ctrl;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic dropped;
    logic [35:0] req;
    logic [7:0] cnt;
    logic [3:0][7:0] age;
    logic [4:0] wd;
    logic [3:0] wb;
    logic [31:0] rd_out;
    logic cke, cs_n, ras_n, cas_n, we_n, oe_n;
    logic [2:0] ba;
    logic [12:0] addr;
  } daao_ctl_t;
  daao_ctl_t s, next_s;
  logic push, f_ready, f_valid, pop;
  logic [35:0] f_data;
  logic [4:0] rl;
  logic [3:0] beats;

  assign push = reg_wr && reg_addr == `DAAO_REG_CMD;
  assign rl = 5'(s.ctrl[5:3]) + 5'(s.ctrl[2:0]);
  assign beats = s.ctrl[6] ? 4'h8 : 4'h4;
  assign pop = s.st == C_IDLE && f_valid && !s.ctrl[10] && s.age[3] >= 8'(FAW_CK);

  daao_fifo #(.WIDTH(36), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk), .reset(reset), .s_valid(push), .s_ready(f_ready),
    .s_data({reg_wdata[19:0], s.wdata}), .m_valid(f_valid), .m_ready(pop), .m_data(f_data)
  );

  always_comb begin
    next_s = s;
    {next_s.cs_n, next_s.ras_n, next_s.cas_n, next_s.we_n} = 4'hf;
    next_s.rd_out = 32'h0;
    // ****** register port ******
    if (reg_wr && reg_addr == `DAAO_REG_CTRL) next_s.ctrl = reg_wdata[11:0];
    if (reg_wr && reg_addr == `DAAO_REG_WDATA) next_s.wdata = reg_wdata[15:0];
    if (push && !f_ready) next_s.dropped = 1'b1;
    if (reg_rd) begin
      unique case (reg_addr)
        `DAAO_REG_CTRL: next_s.rd_out = {20'h0, s.ctrl};
        `DAAO_REG_WDATA: next_s.rd_out = {16'h0, s.wdata};
        `DAAO_REG_STATUS: next_s.rd_out = {28'h0, s.st == C_SREF, s.dropped, !f_ready,
                                           s.st != C_IDLE || f_valid};
        `DAAO_REG_RDATA: next_s.rd_out = {16'h0, s.rdata};
        default: next_s.rd_out = 32'h0;
      endcase
    end
    // reading status clears the drop flag unless a new drop lands now
    if (reg_rd && reg_addr == `DAAO_REG_STATUS && !(push && !f_ready)) next_s.dropped = 1'b0;
    // ****** activate ages, saturating ******
    for (int i = 0; i < 4; i++) if (s.age[i] != 8'hff) next_s.age[i] = s.age[i] + 8'h1;
    // ****** write data and read capture ******
    next_s.oe_n = 1'b1;
    if (s.wd != 5'h0) next_s.wd = s.wd - 5'h1;
    else if (s.wb != 4'h0) begin
      next_s.oe_n = 1'b0;
      next_s.wb = s.wb - 4'h1;
    end
    if (link.dev_dqs) next_s.rdata = link.dq;
    if (reg_wr && reg_addr == `DAAO_REG_CTRL && reg_wdata[11]) next_s.st = C_MODE;
    // ****** sequencer ******
    unique case (s.st)
      C_IDLE: begin
        if (s.ctrl[10]) begin
          {next_s.cs_n, next_s.ras_n, next_s.cas_n, next_s.we_n} = 4'h1;
          next_s.cke = 1'b0;
          next_s.st = C_SREF;
        end else if (pop) begin
          next_s.req = f_data;
          next_s.age = {s.age[2:0], 8'h0};
          {next_s.cs_n, next_s.ras_n, next_s.cas_n, next_s.we_n} = 4'h3;
          next_s.ba = f_data[19:17];
          next_s.addr = f_data[32:20];
          next_s.st = C_COL;
        end
      end
      C_MODE: begin
        // mode register, then the first extended one, a short gap between them
        if (s.cnt == 8'h0) begin
          {next_s.cs_n, next_s.ras_n, next_s.cas_n, next_s.we_n} = 4'h0;
          next_s.ba = 3'h0;
          next_s.addr = {6'h0, s.ctrl[2:0], 1'b0, s.ctrl[6] ? `DAAO_BL8 : `DAAO_BL4};
          next_s.cnt = `DAAO_MODE_WAIT;
        end else if (s.cnt == 8'h1) begin
          {next_s.cs_n, next_s.ras_n, next_s.cas_n, next_s.we_n} = 4'h0;
          next_s.ba = 3'h1;
          next_s.addr = {6'h0, s.ctrl[8], s.ctrl[5:3], s.ctrl[7], 2'h0};
          next_s.cnt = 8'h0;
          next_s.st = C_IDLE;
        end else next_s.cnt = s.cnt - 8'h1;
        if (s.cnt == 8'h0) next_s.st = C_MODE;
      end
      C_COL: begin
        // issued the cycle after activate; software sets additive latency
        {next_s.cs_n, next_s.ras_n, next_s.cas_n} = 3'h2;
        next_s.we_n = !s.req[16];
        next_s.addr = {10'h0, s.req[35:33]};
        if (s.req[16]) begin
          next_s.wd = rl - 5'd2;
          next_s.wb = beats;
        end
        next_s.cnt = 8'(rl) + 8'(beats) + 8'h2;
        next_s.st = C_HOLD;
      end
      C_HOLD: begin
        next_s.cnt = s.cnt - 8'h1;
        if (s.cnt == 8'h0) next_s.st = C_PRE;
      end
      C_PRE: begin
        {next_s.cs_n, next_s.ras_n, next_s.cas_n, next_s.we_n} = 4'h2;
        next_s.addr = 13'h0400;
        next_s.cnt = 8'(TRP_CK) + 8'h1;
        next_s.st = C_WAITP;
      end
      C_WAITP: begin
        next_s.cnt = s.cnt - 8'h1;
        if (s.cnt <= 8'h1) next_s.st = C_IDLE;
      end
      C_SREF: begin
        if (!s.ctrl[10]) begin
          next_s.cke = 1'b1;
          next_s.cnt = 8'(TRP_CK);
          next_s.st = C_WAITP;
        end
      end
      default: next_s.st = C_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s <= '0;
      s.st <= C_IDLE;
      s.ctrl <= `DAAO_CTRL_RESET;
      s.age <= {4{8'hff}};
      s.cke <= 1'b1;
      {s.cs_n, s.ras_n, s.cas_n, s.we_n, s.oe_n} <= 5'h1f;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rd_out;
  assign link.cke = s.cke;
  assign link.cs_n = s.cs_n;
  assign link.ras_n = s.ras_n;
  assign link.cas_n = s.cas_n;
  assign link.we_n = s.we_n;
  assign link.ba = s.ba;
  assign link.addr = s.addr;
  assign link.odt = s.ctrl[9];
  assign link.dm = 2'h0;
  assign link.ctl_dq = s.req[15:0]; // data queued with the request
  assign link.ctl_dq_oe_n = s.oe_n;
endmodule // daao_ctrl
`default_nettype wire

/* core/daao_regs.svh */
// constants of the activate / column access / termination block
`ifndef DAAO_REGS_SVH
`define DAAO_REGS_SVH
// ****************************************
// timing
// ****************************************
`define DAAO_TCK_NS 20
`define DAAO_TFAW_NS 45
`define DAAO_TRP_NS 15
`define DAAO_FAW_CK ((`DAAO_TFAW_NS + `DAAO_TCK_NS - 1) / `DAAO_TCK_NS)
`define DAAO_TRP_CK ((`DAAO_TRP_NS + `DAAO_TCK_NS - 1) / `DAAO_TCK_NS)
`define DAAO_MODE_WAIT 8'h02
// ****************************************
// mode register fields
// ****************************************
`define DAAO_BL_LSB 0
`define DAAO_CL_LSB 4
`define DAAO_AL_LSB 3
`define DAAO_RTT_HI 6
`define DAAO_RTT_LO 2
`define DAAO_BL4 3'h2
`define DAAO_BL8 3'h3
`define DAAO_RTT_OFF 2'h0
`define DAAO_RTT_75 2'h1
`define DAAO_RTT_150 2'h2
`define DAAO_RTT_50 2'h3
`define DAAO_CL_RESET 3'h3
`define DAAO_PRE_ALL_BIT 10
// ****************************************
// controller registers
// ****************************************
`define DAAO_REG_CTRL 8'h00
`define DAAO_REG_CMD 8'h04
`define DAAO_REG_WDATA 8'h08
`define DAAO_REG_STATUS 8'h0c
`define DAAO_REG_RDATA 8'h10
`define DAAO_CTRL_RESET 12'h003
`endif

/* core/daao_pkg.sv */
// types shared by both ends of the link
package daao_pkg;
  typedef enum logic [2:0] {
    DAAO_NOP, DAAO_MRS, DAAO_ACT, DAAO_RD, DAAO_WR, DAAO_PRE, DAAO_REF
  } daao_cmd_t;

  // one scheduled data beat inside the device
  typedef struct packed {
    logic v;
    logic wr;
    logic [2:0] bank;
    logic [2:0] col;
  } daao_beat_t;

  // decode of the command pins
  function automatic daao_cmd_t daao_decode(input logic cs_n, input logic ras_n,
                                            input logic cas_n, input logic we_n);
    daao_cmd_t c;
    c = DAAO_NOP;
    if (!cs_n) begin
      unique case ({ras_n, cas_n, we_n})
        3'b000: c = DAAO_MRS;
        3'b011: c = DAAO_ACT;
        3'b101: c = DAAO_RD;
        3'b100: c = DAAO_WR;
        3'b010: c = DAAO_PRE;
        3'b001: c = DAAO_REF;
        default: c = DAAO_NOP;
      endcase
    end
    return c;
  endfunction
endpackage

/* core/daao_link_if.sv */
// link between the memory controller and the memory device
`timescale 1ns/100ps
`default_nettype none
interface daao_link_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [2:0] ba;
  logic [12:0] addr;
  logic odt;
  logic [1:0] dm;
  logic [15:0] ctl_dq;
  logic ctl_dq_oe_n;
  logic [15:0] dev_dq;
  logic dev_dq_oe_n;
  logic dev_dqs;
  logic [15:0] dq;
  // bus level: whoever enables wins, controller first
  assign dq = !ctl_dq_oe_n ? ctl_dq : (!dev_dq_oe_n ? dev_dq : 16'h0000);
  modport ctl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dm, ctl_dq,
               ctl_dq_oe_n, input dq, dev_dqs);
  modport dev (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dm, dq,
               output dev_dq, dev_dq_oe_n, dev_dqs);
endinterface // daao_link_if
`default_nettype wire

/* core/daao_fifo.sv */
// request fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module daao_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  input wire logic mclk, // clock
  input wire logic reset, // sync reset, high
  input wire logic s_valid, // producer has a word
  output logic s_ready, // room for a word
  input wire logic [WIDTH-1:0] s_data, // incoming word
  output logic m_valid, // word available
  input wire logic m_ready, // consumer takes it
  output logic [WIDTH-1:0] m_data // oldest word
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("depth must be a power of two");
  end
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } daao_fifo_t;
  daao_fifo_t s, next_s;
  logic push, pop;

  // honest full and empty come straight from the count
  assign s_ready = s.cnt != (AW+1)'(DEPTH);
  assign m_valid = s.cnt != '0;
  assign m_data = s.mem[s.rp];
  assign push = s_valid && s_ready;
  assign pop = m_valid && m_ready;

  // pointer and count update
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = s_data;
      next_s.wp = s.wp + 1'b1;
    end
    if (pop) next_s.rp = s.rp + 1'b1;
    next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule // daao_fifo
`default_nettype wire

/* core/daao_device.sv */
// memory device end: command decode, banks, posted column access, termination
`timescale 1ns/100ps
`default_nettype none
`include "daao_regs.svh"
module daao_device import daao_pkg::*; #(
  parameter int NSLOT = 24, // depth of the beat schedule
  parameter int WORDS = 64 // stored words: 8 banks x 8 columns
) (
  input wire logic mclk, // clock
  input wire logic reset, // sync reset, high
  daao_link_if.dev link, // pins toward the controller
  output logic termination_switch_one, // 75 ohm leg closed
  output logic termination_switch_two, // 150 ohm leg closed
  output logic termination_switch_three, // 50 ohm leg closed
  output logic in_self_refresh, // device sits in self refresh
  output logic [7:0] bank_open, // one bit per active bank
  output logic misuse // sticky: column access to a closed bank
);
  // ****************************************
  // state
  // ****************************************
  // longest read latency 7+7 plus a burst of 8 must fit the schedule
  if (NSLOT < 22) begin : g_bad_nslot
    $error("NSLOT too small for the longest latency");
  end
  if (WORDS != 64) begin : g_bad_words
    $error("storage is addressed by bank and 3 column bits");
  end

  typedef struct packed {
    logic [WORDS-1:0][15:0] mem;
    logic [NSLOT-1:0] [$bits(daao_beat_t)-1:0] sched;
    logic [7:0] open;
    // rows are kept per bank, but the small storage ignores them
    logic [7:0][12:0] row;
    logic [2:0] cl;
    logic [2:0] al;
    logic bl8;
    logic [1:0] rtt;
    logic sr;
    logic [15:0] dq;
    logic dq_oe_n;
    logic dqs;
    logic [2:0] sw;
    logic misuse;
  } daao_dev_t;

  daao_dev_t s, next_s;
  daao_cmd_t cmd;
  daao_beat_t head;
  daao_beat_t beat;
  logic [4:0] rl;
  logic [4:0] start;
  logic [5:0] idx;

  // commands are decoded from the pins whatever the level of the clock enable pin
  assign cmd = daao_decode(link.cs_n, link.ras_n, link.cas_n, link.we_n);
  assign head = daao_beat_t'(s.sched[0]);
  // storage word of the beat at the head of the schedule
  assign idx = {head.bank, head.col};
  // write beats land one clock earlier than read beats
  assign rl = 5'(s.al) + 5'(s.cl);

  // ****************************************
  // next state
  // ****************************************
  // every beat of a burst owns one slot of the schedule, so the shift
  // register replaces a per command counter; the cost is NSLOT beats of
  // flip-flops, traded for a command that is never refused while an
  // older burst is still in flight
  always_comb begin
    next_s = s;
    beat = '0;
    start = '0;

    // the schedule advances one beat per clock
    for (int i = 0; i < NSLOT - 1; i++) begin
      next_s.sched[i] = s.sched[i+1];
    end
    next_s.sched[NSLOT-1] = '0;
    next_s.dq_oe_n = 1'b1;
    next_s.dqs = 1'b0;

    // execute the beat at the head: read drives, write samples
    if (head.v && !head.wr) begin
      next_s.dq = s.mem[idx];
      next_s.dq_oe_n = 1'b0;
      next_s.dqs = 1'b1;
    end
    // a byte with its mask high keeps its stored value
    if (head.v && head.wr) begin
      for (int b = 0; b < 2; b++) begin
        if (!link.dm[b]) next_s.mem[idx][b*8 +: 8] = link.dq[b*8 +: 8];
      end
    end

    // self refresh: entered by refresh with clock enable low, left when it rises
    if (s.sr) begin
      if (link.cke) next_s.sr = 1'b0;
    end else if (!link.cke && cmd == DAAO_REF) begin
      next_s.sr = 1'b1;
    end

    // no command is executed here while asleep or with the clock enable low
    if (link.cke && !s.sr) begin
      unique case (cmd)
        DAAO_MRS: begin
          // bank pins pick the mode register or the first extended one
          if (link.ba == 3'h0) begin
            next_s.cl = link.addr[`DAAO_CL_LSB +: 3];
            next_s.bl8 = link.addr[`DAAO_BL_LSB +: 3] == `DAAO_BL8;
          end else if (link.ba == 3'h1) begin
            next_s.al = link.addr[`DAAO_AL_LSB +: 3];
            next_s.rtt = {link.addr[`DAAO_RTT_HI], link.addr[`DAAO_RTT_LO]};
          end
        end
        DAAO_ACT: begin
          next_s.open[link.ba] = 1'b1;
          next_s.row[link.ba] = link.addr;
        end
        DAAO_PRE: begin
          if (link.addr[`DAAO_PRE_ALL_BIT]) begin
            next_s.open = '0;
          end else begin
            next_s.open[link.ba] = 1'b0;
          end
        end
        DAAO_RD, DAAO_WR: begin
          // accepted even in the cycle right after activate; the open flag
          // was set at that edge, so no gap is forced here
          // sticky until reset, so a single slip is never lost
          if (!s.open[link.ba]) next_s.misuse = 1'b1;
          // posted: the beats land after additive plus column latency
          start = (cmd == DAAO_WR) ? rl - 5'd2 : rl - 5'd1;
          beat.v = 1'b1;
          beat.wr = cmd == DAAO_WR;
          beat.bank = link.ba;
          for (int i = 0; i < 8; i++) begin
            // wrap inside the 4 or 8 word segment of the page
            if (s.bl8) beat.col = link.addr[2:0] + 3'(i);
            else beat.col = {link.addr[2], link.addr[1:0] + 2'(i)};
            // a later command overwrites only its own slots, so bursts
            // issued one burst apart stream with no idle beat
            if (i < 4 || s.bl8) next_s.sched[int'(start) + i] = beat;
          end
        end
        default: begin
          // refresh and no operation leave the banks as they are
        end
      endcase
    end

    // termination: pin level, extended mode value, never in self refresh
    // the value in force after this edge is used, so an extended mode
    // write or a self refresh entry in the same clock already counts
    next_s.sw = 3'h0;
    if (link.odt && !next_s.sr) begin
      unique case (next_s.rtt)
        `DAAO_RTT_75: next_s.sw = 3'h1;
        `DAAO_RTT_150: next_s.sw = 3'h2;
        `DAAO_RTT_50: next_s.sw = 3'h4;
        default: next_s.sw = 3'h0;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // storage keeps its contents across reset, the rest starts clean
  // clearing the schedule stops a stale beat driving the bus after reset
  always_ff @(posedge mclk) begin
    if (reset) begin
      s.sched <= '0;
      s.open <= '0;
      s.row <= '0;
      s.cl <= `DAAO_CL_RESET;
      s.al <= 3'h0;
      s.bl8 <= 1'b0;
      s.rtt <= `DAAO_RTT_OFF;
      s.sr <= 1'b0;
      s.dq <= 16'h0000;
      s.dq_oe_n <= 1'b1;
      s.dqs <= 1'b0;
      s.sw <= 3'h0;
      s.misuse <= 1'b0;
      s.mem <= next_s.mem;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // outputs, all straight from flip-flops
  // ****************************************
  // the device lets go of the data pins between read beats
  assign link.dev_dq = s.dq;
  assign link.dev_dq_oe_n = s.dq_oe_n;
  assign link.dev_dqs = s.dqs;
  assign termination_switch_one = s.sw[0];
  assign termination_switch_two = s.sw[1];
  assign termination_switch_three = s.sw[2];
  assign in_self_refresh = s.sr;
  assign bank_open = s.open;
  assign misuse = s.misuse;
endmodule // daao_device
`default_nettype wire

/* sim/daao_link_asserts.sv */
// assertions on the link between the controller end and the device end
`timescale 1ns/100ps
`default_nettype none
module daao_link_asserts #(
  parameter int FAW_CK = 10, // rolling activate window, clocks
  parameter int TRP_CK = 2 // single bank precharge, clocks
) (
  input wire logic mclk, // clock
  input wire logic reset, // sync reset, high
  input wire logic cs_n, // chip select, low
  input wire logic ras_n, // row strobe, low
  input wire logic cas_n, // column strobe, low
  input wire logic we_n, // write enable, low
  input wire logic [2:0] ba, // bank address
  input wire logic [12:0] addr, // row or column address
  input wire logic ctl_dq_oe_n, // controller drives dq, low
  input wire logic dev_dq_oe_n, // device drives dq, low
  input wire logic dev_dqs // read beat strobe
);
  // ****************************************
  // decode and shadow state
  // ****************************************
  logic act, col, mrs, pre, idle, bl8, exp_rd, exp_wr;
  logic [2:0] cl, al;
  logic [3:0] rl;
  logic [7:0] open_b;
  logic [31:0] rd_h, wr_h, act_h;
  int n_act, gap;
  // command decode done here, apart from the design's own decoder
  assign act = !cs_n && !ras_n && cas_n && we_n;
  assign col = !cs_n && ras_n && !cas_n;
  assign mrs = !cs_n && !ras_n && !cas_n && !we_n;
  assign pre = !cs_n && !ras_n && cas_n && !we_n;
  assign idle = cs_n || (ras_n && cas_n && we_n);
  assign rl = {1'b0, al} + {1'b0, cl};
  // latencies are shadowed from the mode writes seen on the pins, not taken from the device
  always_ff @(posedge mclk) begin
    if (reset) begin
      cl <= 3'h3;
      al <= 3'h0;
      bl8 <= 1'b0;
      open_b <= 8'h00;
      rd_h <= 32'h0;
      wr_h <= 32'h0;
      act_h <= 32'h0;
      gap <= 0;
    end else begin
      rd_h <= {rd_h[30:0], col && we_n};
      wr_h <= {wr_h[30:0], col && !we_n};
      act_h <= {act_h[30:0], act};
      gap <= (pre && addr[10]) ? TRP_CK : (gap > 0 ? gap - 1 : 0);
      if (mrs && ba == 3'h0) begin
        cl <= addr[6:4];
        bl8 <= addr[2:0] == 3'h3;
      end
      if (mrs && ba == 3'h1) al <= addr[5:3];
      if (act) open_b[ba] <= 1'b1;
      if (pre) open_b <= addr[10] ? 8'h00 : open_b & ~(8'h01 << ba);
    end
  end
  // beat slots due from earlier column commands, and recent activates
  always_comb begin
    exp_rd = 1'b0;
    exp_wr = 1'b0;
    n_act = 0;
    for (int i = 0; i < 8; i++) begin
      if (i < 4 || bl8) begin
        exp_rd = exp_rd | rd_h[rl + i];
        exp_wr = exp_wr | wr_h[rl - 2 + i];
      end
    end
    for (int i = 0; i < FAW_CK - 1; i++) n_act = n_act + act_h[i];
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  a_rd_latency: assert property (dev_dqs == exp_rd)
    else $error("read beat off its latency slot");
  a_wr_latency: assert property (exp_wr |-> !ctl_dq_oe_n)
    else $error("write beat not driven at its slot");
  a_rd_direction: assert property (dev_dqs |-> !dev_dq_oe_n && ctl_dq_oe_n)
    else $error("read beat with wrong bus owner");
  a_faw_limit: assert property (act |-> n_act <= 3)
    else $error("fifth activate inside window");
  a_pre_all_gap: assert property (gap != 0 |-> idle)
    else $error("command too soon after precharge all");
  a_open_before: assert property (col |-> open_b[ba])
    else $error("column access to closed bank");
  a_col_follows: assert property (act |=> col && $past(ba) == ba)
    else $error("column command not right after activate");
  a_mode_closed: assert property (mrs |-> open_b == 8'h00)
    else $error("mode write with a bank open");
  c_read: cover property (col && we_n ##1 1'b1 [*2] ##1 dev_dqs);
  c_write: cover property (col && !we_n);
  c_pre_all: cover property (pre && addr[10]);
endmodule // daao_link_asserts
`default_nettype wire

/* sim/tb_top.sv */
// bench: register port drives the controller, the device answers on the link
`timescale 1ns/100ps
`default_nettype none
`include "daao_regs.svh"
module tb_top;
  // ****************************************
  // design, link and checker
  // ****************************************
  logic mclk, reset, reg_wr, reg_rd, sw_one, sw_two, sw_three, in_sr, misuse;
  logic [7:0] reg_addr, bank_open;
  logic [31:0] reg_wdata, reg_rdata, rv;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int seed = 32'h984f;
  daao_link_if link();
  daao_ctrl #(.FAW_CK(10), .TRP_CK(2)) i_daao_ctrl (.mclk(mclk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .link(link.ctl));
  daao_device i_daao_device (.mclk(mclk), .reset(reset), .link(link.dev),
    .termination_switch_one(sw_one), .termination_switch_two(sw_two),
    .termination_switch_three(sw_three), .in_self_refresh(in_sr), .bank_open(bank_open),
    .misuse(misuse));
  daao_link_asserts #(.FAW_CK(10), .TRP_CK(2)) i_daao_link_asserts (.mclk(mclk),
    .reset(reset), .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n),
    .we_n(link.we_n), .ba(link.ba), .addr(link.addr), .ctl_dq_oe_n(link.ctl_dq_oe_n),
    .dev_dq_oe_n(link.dev_dq_oe_n), .dev_dqs(link.dev_dqs));
  // 20 ns clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // cut a hang short, far beyond the few thousand cycles the run needs
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_count++;
      give_verdict();
    end
  end
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] ctrl_word(input int cl, al, bl8, rtt, odt);
    return {22'h0, odt[0], rtt[1:0], bl8[0], al[2:0], cl[2:0]};
  endfunction
  // legs closed: none when the pin is low or the field is zero
  function automatic logic [2:0] term_exp(input int rtt, odt);
    return odt ? 3'((1 << rtt) >> 1) : 3'h0;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (err_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one-cycle strobes, changed just after the edge
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // poll busy under a bound; the request needs a few cycles to reach the sequencer
  task automatic wait_idle;
    int n;
    n = 0;
    rv = 32'h1;
    repeat (4) @(posedge mclk);
    while (rv[0] && n < 300) begin
      rd_reg(`DAAO_REG_STATUS, rv);
      n++;
    end
    check(rv[0], 1'b0);
  endtask
  // mode bits only reach the device through the program pulse
  task automatic set_mode(input logic [31:0] w);
    wr_reg(`DAAO_REG_CTRL, w);
    wr_reg(`DAAO_REG_CTRL, w | 32'h800);
    repeat (12) @(posedge mclk);
  endtask
  task automatic access(input logic wr, input logic [2:0] b, c, input logic [15:0] d);
    wr_reg(`DAAO_REG_WDATA, {16'h0, d});
    wr_reg(`DAAO_REG_CMD, {12'h0, c, 13'($random(seed)), b, wr});
    wait_idle();
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [31:0] v, w;
    logic [2:0] b, c;
    logic [15:0] d;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reset = 1'b1;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    rd_reg(`DAAO_REG_CTRL, v);
    check(v, {20'h0, `DAAO_CTRL_RESET});
    rd_reg(8'h14, v);
    check(v, 32'h0);
    // every field code with the pin low and high, then self refresh over it
    for (int t = 0; t < 8; t++) begin
      w = ctrl_word(3, 0, 0, t >> 1, t & 1);
      set_mode(w);
      check({sw_three, sw_two, sw_one}, term_exp(t >> 1, t & 1));
      wr_reg(`DAAO_REG_CTRL, w | 32'h400);
      repeat (12) @(posedge mclk);
      rd_reg(`DAAO_REG_STATUS, v);
      check({v[3], in_sr, sw_three, sw_two, sw_one}, 5'h18);
      wr_reg(`DAAO_REG_CTRL, w);
      repeat (12) @(posedge mclk);
      check({in_sr, sw_three, sw_two, sw_one}, {1'b0, term_exp(t >> 1, t & 1)});
    end
    // random latencies and burst lengths; a neighbour bank write must not leak in
    for (int k = 0; k < 12; k++) begin
      rv = $random(seed);
      if (k == 0) rv = 32'h0; // shortest latency, short bursts
      if (k == 1) rv[5:0] = 6'h3e; // longest latency, long bursts
      b = rv[8:6];
      c = rv[11:9];
      d = rv[31:16];
      set_mode(ctrl_word(3 + rv[1:0] % 3, rv[4:2] % 4, rv[5], 1, 0));
      access(1'b1, b, c, d);
      access(1'b1, b ^ 3'h1, c, ~d);
      access(1'b0, b, c ^ 3'h1, 16'h0);
      rd_reg(`DAAO_REG_RDATA, v);
      check(v[15:0], d);
      check({misuse, bank_open}, 9'h000);
    end
    // flood the request queue faster than the sequencer drains it
    for (int k = 0; k < 12; k++) wr_reg(`DAAO_REG_CMD, {12'h0, 3'h2, 13'h0, 3'h5, 1'b1});
    rd_reg(`DAAO_REG_STATUS, v);
    check(v[2:1], 2'h3);
    rd_reg(`DAAO_REG_STATUS, v);
    check(v[2], 1'b0);
    wait_idle();
    rd_reg(`DAAO_REG_STATUS, v);
    check(v, 32'h0);
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
